// *** hw/lockin_udp_stream_framer.sv ***
// udp stream framer: packs lock-in samples into header plus payload
`timescale 1ns/100ps
module lockin_udp_stream_framer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic stream_start_command,
  input wire logic stream_stop_command,
  input wire logic [31:0] requester_ip,
  input wire logic smp_valid,
  input wire stream_framer_pkg::sample_t smp,
  input wire logic [4:0] base_rate,
  input wire stream_framer_pkg::cond_t cond,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_first,
  output logic tx_last,
  input wire logic tx_ready,
  output stream_framer_pkg::frame_t tx_frame
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // payload bytes for a size code
  function automatic logic [10:0] len_of(input logic [1:0] code);
    len_of = stream_framer_pkg::MAX_PAYLOAD >> code;
  endfunction : len_of

  // channel mask {phase, mag, y, x} for a content code
  function automatic logic [3:0] mask_of(input logic [2:0] content);
    case (content[1:0])
      2'h0: mask_of = 4'h1;
      2'h1: mask_of = 4'h3;
      2'h2: mask_of = 4'hc;
      default: mask_of = 4'hf;
    endcase
  endfunction : mask_of

  // bytes in transmit order, first byte in [31:24]
  function automatic logic [31:0] order_bytes(input logic [31:0] w,
                                              input logic is_int,
                                              input logic le);
    if (is_int) begin
      order_bytes = le ? {w[7:0], w[15:8], 16'h0000}
                       : {w[15:8], w[7:0], 16'h0000};
    end else begin
      order_bytes = le ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    end
  endfunction : order_bytes

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [6:0] cfg_q;
  logic [4:0] subrate_q;
  logic [15:0] dport_q;
  logic [31:0] dest_ip_q;
  logic run_q;
  logic drop_q;
  logic [7:0] cnt_q;

  wire logic wr_cfg = reg_wr && (reg_addr == stream_framer_pkg::ADDR_CFG);
  wire logic wr_sub = reg_wr &&
    (reg_addr == stream_framer_pkg::ADDR_SUBRATE);
  wire logic wr_port = reg_wr &&
    (reg_addr == stream_framer_pkg::ADDR_DPORT);

  logic [31:0] rd_mux;
  wire logic tx_busy;
  always_comb begin
    case (reg_addr)
      stream_framer_pkg::ADDR_CFG: rd_mux = {25'h0000000, cfg_q};
      stream_framer_pkg::ADDR_SUBRATE: rd_mux = {27'h0000000, subrate_q};
      stream_framer_pkg::ADDR_DPORT: rd_mux = {16'h0000, dport_q};
      stream_framer_pkg::ADDR_STATUS:
        rd_mux = {21'h000000, tx_busy, drop_q, run_q, cnt_q};
      stream_framer_pkg::ADDR_DEST_IP: rd_mux = dest_ip_q;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_q <= stream_framer_pkg::CFG_RESET;
      subrate_q <= stream_framer_pkg::SUBRATE_RESET;
      dport_q <= stream_framer_pkg::DPORT_RESET;
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      if (wr_cfg) begin
        cfg_q <= reg_wdata[6:0];
      end
      if (wr_sub) begin
        subrate_q <= reg_wdata[4:0];
      end
      if (wr_port) begin
        dport_q <= reg_wdata[15:0];
      end
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // stream control and subsampling
  // ---------------------------------------------------------------
  logic [30:0] dec_q;
  wire logic [30:0] dec_mask = 31'((32'h1 << subrate_q) - 32'h1);
  wire logic dec_hit = (dec_q & dec_mask) == 31'h00000000;

  // effective rate, saturates at slowest code
  wire logic [5:0] rate_sum = {1'b0, base_rate} + {1'b0, subrate_q};
  wire logic [4:0] rate_eff = rate_sum[5] ? stream_framer_pkg::RATE_MAX
                                          : rate_sum[4:0];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      dest_ip_q <= 32'h00000000;
      dec_q <= 31'h00000000;
    end else if (ce) begin
      if (stream_start_command) begin
        run_q <= 1'b1;
        dest_ip_q <= requester_ip;
        dec_q <= 31'h00000000;
      end else begin
        if (stream_stop_command) begin
          run_q <= 1'b0;
        end
        if (smp_valid) begin
          dec_q <= dec_q + 31'h00000001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // payload fill into two banks
  // ---------------------------------------------------------------
  // two banks so one fills while the other drains
  logic [7:0] mem [0:2047];
  logic fb_q;
  logic tb_q;
  logic [1:0] full_q;
  logic [10:0] wr_ptr_q;
  logic [3:0] pend_q;
  stream_framer_pkg::sample_t smp_q;
  stream_framer_pkg::pkt_cfg_t pk_q;
  logic [31:0] hdr_q [0:1];

  wire stream_framer_pkg::pkt_cfg_t cfg_now = '{
    le: cfg_q[stream_framer_pkg::CFG_LE],
    csum: cfg_q[stream_framer_pkg::CFG_CSUM],
    content: cfg_q[stream_framer_pkg::CFG_CONTENT_LO +: 3],
    size: cfg_q[stream_framer_pkg::CFG_SIZE_LO +: 2],
    rate: rate_eff
  };

  wire logic accept = run_q && smp_valid && dec_hit &&
    (pend_q == 4'h0) && !stream_start_command;

  wire logic [1:0] ch = pend_q[0] ? 2'd0 : pend_q[1] ? 2'd1 :
                        pend_q[2] ? 2'd2 : 2'd3;
  wire logic is_int = pk_q.content[2];
  wire logic [79:0] int_lanes = {16'h0000, smp_q.x_i, smp_q.y_i, smp_q.r_i,
                                 smp_q.t_i};
  wire logic [127:0] flt_lanes = {smp_q.x_f, smp_q.y_f, smp_q.r_f, smp_q.t_f};
  wire logic [79:0] int_sh = int_lanes >> (7'(3 - ch) * 16);
  wire logic [127:0] flt_sh = flt_lanes >> (7'(3 - ch) * 32);
  wire logic [31:0] ch_word = is_int ? int_sh[31:0] : flt_sh[31:0];
  wire logic [31:0] lanes = order_bytes(ch_word, is_int, pk_q.le);
  wire logic [10:0] step = is_int ? 11'h002 : 11'h004;
  wire logic [10:0] wr_next = wr_ptr_q + step;
  wire logic [10:0] pk_len = len_of(pk_q.size);
  // a start in this cycle must not complete a bank behind control; a stop does not gate it
  wire logic do_write = run_q && !stream_start_command &&
    (pend_q != 4'h0) && !full_q[fb_q];
  // bank completes only at the exact payload length
  wire logic fill_done = do_write && (wr_next == pk_len);

  wire logic ovl_now = cond.in_ovl || (cond.sync_on && cond.sync_ovl) ||
    (pk_q.content >= stream_framer_pkg::CONTENT_INT && cond.out_ovl);
  wire logic err_now = cond.pll_unlock || cond.sync_range;

  logic [31:0] hdr_new;
  always_comb begin
    hdr_new = 32'h00000000;
    hdr_new[stream_framer_pkg::HDR_CNT_LO +: 8] = cnt_q;
    hdr_new[stream_framer_pkg::HDR_CONTENT_LO +: 4] = {1'b0, pk_q.content};
    hdr_new[stream_framer_pkg::HDR_LEN_LO +: 4] = {2'b00, pk_q.size};
    hdr_new[stream_framer_pkg::HDR_RATE_LO +: 8] = {3'b000, pk_q.rate};
    hdr_new[stream_framer_pkg::HDR_OVL] = ovl_now;
    hdr_new[stream_framer_pkg::HDR_ERR] = err_now;
    hdr_new[stream_framer_pkg::HDR_LE] = pk_q.le;
    hdr_new[stream_framer_pkg::HDR_CSUM] = pk_q.csum;
  end

  always_ff @(posedge sys_clk) begin
    if (do_write && ce && rst_n) begin
      for (int k = 0; k < 4; k++) begin
        if (11'(k) < step) begin
          mem[{fb_q, 10'(wr_ptr_q + 11'(k))}] <= lanes[31 - 8 * k -: 8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fb_q <= 1'b0;
      wr_ptr_q <= 11'h000;
      pend_q <= 4'h0;
      smp_q <= '0;
      pk_q <= '0;
      cnt_q <= 8'h00;
      drop_q <= 1'b0;
      hdr_q[0] <= 32'h00000000;
      hdr_q[1] <= 32'h00000000;
    end else if (ce) begin
      if (stream_start_command || !run_q) begin
        // abandon any partial packet
        wr_ptr_q <= 11'h000;
        pend_q <= 4'h0;
        if (stream_start_command) begin
          drop_q <= 1'b0;
        end
      end else if (accept) begin
        smp_q <= smp;
        // size held steady for the whole packet
        if (wr_ptr_q == 11'h000) begin
          pk_q <= cfg_now;
          pend_q <= mask_of(cfg_now.content);
        end else begin
          pend_q <= mask_of(pk_q.content);
        end
      end else if (pend_q != 4'h0 && full_q[fb_q]) begin
        // both banks busy: whole sample is lost
        pend_q <= 4'h0;
        drop_q <= 1'b1;
      end else if (do_write) begin
        pend_q[ch] <= 1'b0;
        if (wr_ptr_q == 11'h000) begin
          hdr_q[fb_q] <= hdr_new;
        end
        if (fill_done) begin
          wr_ptr_q <= 11'h000;
          fb_q <= ~fb_q;
          cnt_q <= cnt_q + 8'h01;
        end else begin
          wr_ptr_q <= wr_next;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit
  // ---------------------------------------------------------------
  stream_framer_pkg::tx_state_t tx_st_q;
  logic [1:0] hidx_q;
  logic [10:0] rd_ptr_q;
  wire logic hs = tx_valid && tx_ready;
  wire logic [31:0] hdr_cur = hdr_q[tb_q];
  wire logic [10:0] tx_len = len_of(hdr_cur[stream_framer_pkg::HDR_LEN_LO +: 2]);
  wire logic [7:0] rd_byte = mem[{tb_q, rd_ptr_q[9:0]}];
  wire logic [7:0] hdr_byte = hdr_cur[8'(31 - 8 * (int'(hidx_q) + 1)) -: 8];
  wire logic tx_done = (tx_st_q == stream_framer_pkg::TX_PAY) && hs && tx_last;
  assign tx_busy = tx_st_q != stream_framer_pkg::TX_IDLE;

  // full flags: a fill sets one bank while transmit clears the other
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      full_q <= 2'b00;
    end else if (ce) begin
      for (int b = 0; b < 2; b++) begin
        if (fill_done && fb_q == 1'(b)) begin
          full_q[b] <= 1'b1;
        end else if (tx_done && tb_q == 1'(b)) begin
          full_q[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_st_q <= stream_framer_pkg::TX_IDLE;
      tb_q <= 1'b0;
      hidx_q <= 2'h0;
      rd_ptr_q <= 11'h000;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_first <= 1'b0;
      tx_last <= 1'b0;
      tx_frame <= '0;
    end else if (ce) begin
      case (tx_st_q)
        stream_framer_pkg::TX_IDLE: begin
          if (full_q[tb_q]) begin
            // header leads, always most significant byte first
            tx_st_q <= stream_framer_pkg::TX_HDR;
            tx_valid <= 1'b1;
            tx_first <= 1'b1;
            tx_data <= hdr_cur[31:24];
            hidx_q <= 2'h0;
            tx_frame <= '{dest_ip: dest_ip_q, dest_port: dport_q,
                          csum_en: hdr_cur[stream_framer_pkg::HDR_CSUM],
                          len: tx_len};
          end
        end
        stream_framer_pkg::TX_HDR: begin
          if (hs) begin
            tx_first <= 1'b0;
            if (hidx_q == stream_framer_pkg::HDR_LAST_BYTE) begin
              tx_st_q <= stream_framer_pkg::TX_PAY;
              tx_data <= rd_byte;
              rd_ptr_q <= 11'h001;
            end else begin
              tx_data <= hdr_byte;
              hidx_q <= hidx_q + 2'h1;
            end
          end
        end
        stream_framer_pkg::TX_PAY: begin
          if (hs) begin
            if (tx_last) begin
              tx_st_q <= stream_framer_pkg::TX_IDLE;
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              tb_q <= ~tb_q;
              rd_ptr_q <= 11'h000;
            end else begin
              tx_data <= rd_byte;
              tx_last <= rd_ptr_q == tx_len - 11'h001;
              rd_ptr_q <= rd_ptr_q + 11'h001;
            end
          end
        end
        default: begin
          tx_st_q <= stream_framer_pkg::TX_IDLE;
          tx_valid <= 1'b0;
        end
      endcase
    end
  end

endmodule : lockin_udp_stream_framer

// *** hw/stream_framer_pkg.sv ***
// shared constants, field layouts and carrier types for the stream framer
package stream_framer_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_SUBRATE = 8'h04;
  localparam logic [7:0] ADDR_DPORT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_DEST_IP = 8'h10;

  // cfg register fields
  localparam int CFG_LE = 0;
  localparam int CFG_CSUM = 1;
  localparam int CFG_CONTENT_LO = 2;
  localparam int CFG_SIZE_LO = 5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] DPORT_RESET = 16'h0749;
  localparam logic [6:0] CFG_RESET = 7'h00;
  localparam logic [4:0] SUBRATE_RESET = 5'h00;

  // ---------------------------------------------------------------
  // header layout
  // ---------------------------------------------------------------
  localparam int HDR_CNT_LO = 0;
  localparam int HDR_CONTENT_LO = 8;
  localparam int HDR_LEN_LO = 12;
  localparam int HDR_RATE_LO = 16;
  localparam int HDR_OVL = 24;
  localparam int HDR_ERR = 25;
  localparam int HDR_LE = 28;
  localparam int HDR_CSUM = 29;

  localparam logic [10:0] MAX_PAYLOAD = 11'h400;
  localparam logic [4:0] RATE_MAX = 5'h1f;
  localparam logic [2:0] CONTENT_INT = 3'h4;
  localparam logic [1:0] HDR_LAST_BYTE = 2'h3;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] x_f;
    logic [31:0] y_f;
    logic [31:0] r_f;
    logic [31:0] t_f;
    logic [15:0] x_i;
    logic [15:0] y_i;
    logic [15:0] r_i;
    logic [15:0] t_i;
  } sample_t;

  typedef struct packed {
    logic in_ovl;
    logic sync_on;
    logic sync_ovl;
    logic out_ovl;
    logic pll_unlock;
    logic sync_range;
  } cond_t;

  typedef struct packed {
    logic le;
    logic csum;
    logic [2:0] content;
    logic [1:0] size;
    logic [4:0] rate;
  } pkt_cfg_t;

  typedef struct packed {
    logic [31:0] dest_ip;
    logic [15:0] dest_port;
    logic csum_en;
    logic [10:0] len;
  } frame_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_HDR = 3'b010,
    TX_PAY = 3'b100
  } tx_state_t;

endpackage : stream_framer_pkg

// *** testbench/stream_framer_monitor.sv ***
// checker on the framer's datagram and register ports
`timescale 1ns/100ps
module stream_framer_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire stream_framer_pkg::frame_t tx_frame
);
  // ----------------------------------------
  // byte position within the current frame
  // ----------------------------------------
  logic [10:0] cnt_q;
  logic have_q;
  logic [7:0] last_q;
  wire logic taken = tx_valid && tx_ready;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= 11'h0;
      have_q <= 1'b0;
      last_q <= 8'h00;
    end else if (taken) begin
      cnt_q <= tx_first ? 11'h1 : cnt_q + 11'h1;
      if (cnt_q == 11'h3) begin
        have_q <= 1'b1;
        last_q <= tx_data;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_len;
    tx_valid && tx_first |-> tx_frame.len inside {11'h400, 11'h200,
      11'h100, 11'h080};
  endproperty
  a_len: assert property (p_len) else $error("bad payload length");
  property p_csum;
    tx_valid && tx_first |-> tx_data[5] == tx_frame.csum_en;
  endproperty
  a_csum: assert property (p_csum) else $error("csum flag off");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte lost on stall");
  property p_count_len;
    taken && tx_last |-> cnt_q + 11'h1 == tx_frame.len + 11'h4;
  endproperty
  a_count_len: assert property (p_count_len)
    else $error("frame byte count wrong");
  property p_frame_stable;
    tx_valid && !tx_first |-> $stable(tx_frame);
  endproperty
  a_frame_stable: assert property (p_frame_stable)
    else $error("frame info moved");
  property p_gap;
    taken && tx_last |=> !tx_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle after frame");
  property p_ip;
    reg_rd && reg_addr == stream_framer_pkg::ADDR_DEST_IP &&
      tx_frame.len != 11'h0 |=> reg_rdata == tx_frame.dest_ip;
  endproperty
  a_ip: assert property (p_ip) else $error("dest ip mismatch");
  property p_seq;
    tx_valid && cnt_q == 11'h3 && have_q |-> tx_data == last_q + 8'h1;
  endproperty
  a_seq: assert property (p_seq) else $error("count not sequential");
  property p_rate;
    tx_valid && cnt_q == 11'h1 |-> tx_data <= 8'h1f;
  endproperty
  a_rate: assert property (p_rate) else $error("rate code too big");
endmodule : stream_framer_monitor
bind lockin_udp_stream_framer stream_framer_monitor i_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready),
  .tx_frame(tx_frame)
);

// *** testbench/udp_sink_model.sv ***
// receiving host model: collects datagram bytes, may stall
`timescale 1ns/100ps
module udp_sink_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_first,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] rx_q [0:1027];
  int idx_q;
  int done_q;
  logic [1:0] cyc_q;
  // ----------------------------------------
  // byte intake
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      idx_q <= 0;
      done_q <= 0;
      cyc_q <= 2'h0;
    end else begin
      cyc_q <= cyc_q + 2'h1;
      // slow host takes one byte in four
      tx_ready <= !stall || cyc_q == 2'h0;
      if (tx_valid && tx_ready) begin
        idx_q <= tx_first ? 1 : idx_q + 1;
        rx_q[tx_first ? 0 : idx_q] <= tx_data;
        if (tx_last) done_q <= done_q + 1;
      end
    end
  end
endmodule : udp_sink_model

// *** testbench/lockin_udp_stream_framer_tb_top.sv ***
// self-checking bench for the udp stream framer
`timescale 1ns/100ps
`define CHK(a, b) begin \
  compares++; \
  if ((a) !== (b)) begin \
    n_errors++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); \
  end \
end
module lockin_udp_stream_framer_tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ce = 1'b1;
  logic [31:0] reg_rdata;
  logic stream_start_command = 1'b0;
  logic stream_stop_command = 1'b0;
  logic [31:0] requester_ip = 32'h0;
  logic smp_valid = 1'b0;
  stream_framer_pkg::sample_t smp = '0;
  logic [4:0] base_rate = 5'h00;
  stream_framer_pkg::cond_t cond = '0;
  logic tx_valid, tx_first, tx_last, tx_ready;
  logic [7:0] tx_data;
  stream_framer_pkg::frame_t tx_frame;
  logic stall = 1'b0;
  int n_errors = 0;
  int compares = 0;
  int pkt = 0;
  logic [15:0] port_x = 16'h0749;
  logic [7:0] exp_q [$];
  logic [5:0] cds [0:7] = '{6'h00, 6'h20, 6'h18, 6'h04, 6'h04, 6'h08,
    6'h02, 6'h01};
  lockin_udp_stream_framer i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stream_start_command(stream_start_command),
    .stream_stop_command(stream_stop_command),
    .requester_ip(requester_ip), .smp_valid(smp_valid), .smp(smp),
    .base_rate(base_rate), .cond(cond), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last),
    .tx_ready(tx_ready), .tx_frame(tx_frame));
  udp_sink_model i_sink (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_first(tx_first),
    .tx_last(tx_last), .tx_ready(tx_ready));
  // ----------------------------------------
  // bus and bookkeeping tasks
  // ----------------------------------------
  task automatic summarize();
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    `CHK(d, e)
    @(posedge sys_clk);
  endtask : rchk
  function automatic stream_framer_pkg::sample_t mk(input int k);
    mk = {32'h01234567, 32'h89abcdef, 32'h13579bdf, 32'h2468ace0,
      16'h4567, 16'hcdef, 16'h9bdf, 16'hace0} ^ {24{8'(k)}};
  endfunction : mk
  task automatic push_w(input logic [31:0] v, input logic i, input logic le);
    int nb;
    nb = i ? 2 : 4;
    for (int b = 0; b < nb; b++)
      exp_q.push_back(le ? v[8*b +: 8] : v[8*(nb-1-b) +: 8]);
  endtask : push_w
  task automatic push_smp(input stream_framer_pkg::sample_t s,
      input logic [2:0] cn, input logic le);
    if (cn[1:0] != 2'h2) push_w(cn[2] ? {16'h0, s.x_i} : s.x_f, cn[2], le);
    if (cn[0]) push_w(cn[2] ? {16'h0, s.y_i} : s.y_f, cn[2], le);
    if (cn[1]) push_w(cn[2] ? {16'h0, s.r_i} : s.r_f, cn[2], le);
    if (cn[1]) push_w(cn[2] ? {16'h0, s.t_i} : s.t_f, cn[2], le);
  endtask : push_smp
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reg_check();
    rchk(stream_framer_pkg::ADDR_CFG, 32'h0);
    rchk(stream_framer_pkg::ADDR_DPORT, 32'h749);
    rchk(stream_framer_pkg::ADDR_STATUS, 32'h0);
    wr(stream_framer_pkg::ADDR_SUBRATE, 32'hffffffff);
    rchk(stream_framer_pkg::ADDR_SUBRATE, 32'h1f);
    wr(stream_framer_pkg::ADDR_STATUS, 32'hffffffff);
    rchk(stream_framer_pkg::ADDR_STATUS, 32'h0);
    wr(stream_framer_pkg::ADDR_CFG, 32'hffffffff);
    rchk(stream_framer_pkg::ADDR_CFG, 32'h7f);
    // clock enable low: the write must not land
    ce <= 1'b0;
    wr(stream_framer_pkg::ADDR_CFG, 32'h00000055);
    ce <= 1'b1;
    rchk(stream_framer_pkg::ADDR_CFG, 32'h7f);
    rchk(8'h14, 32'h0);
  endtask : reg_check
  // nfr frames streamed back to back, the last one compared in full
  task automatic run_frame(input logic [2:0] cn, input logic [1:0] sz,
      input logic le, input logic cs, input logic [4:0] sub,
      input logic [4:0] base, input logic [5:0] cd, input logic st,
      input int nfr, input int gap);
    int len, nsmp, k, t, d0;
    logic [4:0] rt;
    logic [31:0] hdr, ip, got;
    logic ovl;
    stream_framer_pkg::sample_t s;
    exp_q.delete();
    len = 1024 >> sz;
    nsmp = len / ((cn[1:0] == 2'h0 ? 1 : cn[1:0] == 2'h3 ? 4 : 2) *
      (cn[2] ? 2 : 4));
    rt = (base + sub > 31) ? 5'h1f : 5'(base + sub);
    ip = 32'hc0a80100 + pkt;
    ovl = cd[5] | (cd[4] & cd[3]) | (cd[2] & cn[2]);
    hdr = {2'h0, cs, le, 2'h0, cd[1] | cd[0], ovl, 3'h0, rt, 2'h0, sz,
      1'b0, cn, 8'(pkt + nfr - 1)};
    wr(stream_framer_pkg::ADDR_CFG, {25'h0, sz, cn, cs, le});
    wr(stream_framer_pkg::ADDR_SUBRATE, {27'h0, sub});
    base_rate <= base;
    cond <= stream_framer_pkg::cond_t'(cd);
    stall <= st;
    requester_ip <= ip;
    d0 = i_sink.done_q;
    stream_start_command <= 1'b1;
    @(posedge sys_clk);
    stream_start_command <= 1'b0;
    rchk(stream_framer_pkg::ADDR_STATUS, {22'h0, 1'b0, 1'b1, 8'(pkt)});
    for (k = 0; k < (nfr * nsmp) << sub; k++) begin
      s = mk(k);
      smp <= s;
      smp_valid <= 1'b1;
      @(posedge sys_clk);
      smp_valid <= 1'b0;
      repeat (gap - 1) @(posedge sys_clk);
      if (k % (1 << sub) == 0 && (k >> sub) >= (nfr - 1) * nsmp)
        push_smp(s, cn, le);
    end
    for (t = 0; i_sink.done_q < d0 + nfr && t < 8000; t++)
      @(posedge sys_clk);
    stream_stop_command <= 1'b1;
    @(posedge sys_clk);
    stream_stop_command <= 1'b0;
    got = {i_sink.rx_q[0], i_sink.rx_q[1], i_sink.rx_q[2], i_sink.rx_q[3]};
    `CHK(i_sink.done_q, d0 + nfr)
    `CHK(i_sink.idx_q, len + 4)
    `CHK(got[7:0], hdr[7:0])
    `CHK(got[11:8], hdr[11:8])
    `CHK(got[15:12], hdr[15:12])
    `CHK(got[23:16], hdr[23:16])
    `CHK(got[25:24], hdr[25:24])
    `CHK(got[29:28], hdr[29:28])
    `CHK({got[31:30], got[27:26]}, 4'h0)
    for (k = 0; k < len; k++)
      `CHK(i_sink.rx_q[k+4],exp_q[k])
    `CHK(tx_frame.dest_ip, ip)
    `CHK(tx_frame.dest_port, port_x)
    `CHK(tx_frame.csum_en, cs)
    `CHK(tx_frame.len, 11'(len))
    rchk(stream_framer_pkg::ADDR_DEST_IP, ip);
    pkt += nfr;
  endtask : run_frame
  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    // well above the roughly 47k cycles the sequence needs
    repeat (90000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    reg_check();
    for (int c = 0; c < 8; c++)
      run_frame(3'(c), 2'h3, c[0], c[1], 5'h0, 5'(c), cds[c], 1'b0, 1, 6);
    run_frame(3'h3, 2'h3, 1'b0, 1'b0, 5'h2, 5'h3, 6'h0, 1'b0, 1, 6);
    run_frame(3'h7, 2'h3, 1'b1, 1'b0, 5'h5, 5'h1e, 6'h0, 1'b0, 1, 6);
    wr(stream_framer_pkg::ADDR_DPORT, 32'h2000);
    port_x = 16'h2000;
    run_frame(3'h3, 2'h0, 1'b0, 1'b1, 5'h0, 5'h0, 6'h24, 1'b1, 1, 6);
    run_frame(3'h3, 2'h3, 1'b1, 1'b1, 5'h0, 5'h0, 6'h0, 1'b0, 250, 18);
    rchk(stream_framer_pkg::ADDR_STATUS, {24'h0, 8'(pkt)});
    summarize();
  end
endmodule : lockin_udp_stream_framer_tb_top
